// [ifbl_pkg.sv]
package ifbl_pkg;

	// ---------------------------------------------------------------
	// Instruction fields
	// ---------------------------------------------------------------
	localparam int IFBL_INSTR_W   = 32;
	localparam int IFBL_OPC_LSB   = 26;
	localparam int IFBL_RS_LSB    = 21;
	localparam int IFBL_RT_LSB    = 16;
	localparam int IFBL_RD_LSB    = 11;
	localparam int IFBL_FUNCT_LSB = 0;
	localparam int IFBL_IMM_W     = 16;
	localparam int IFBL_TGT_W     = 26;

	// ---------------------------------------------------------------
	// Major opcodes
	// ---------------------------------------------------------------
	localparam logic [5:0] IFBL_OP_SPECIAL = 6'h00;
	localparam logic [5:0] IFBL_OP_REGIMM  = 6'h01;
	localparam logic [5:0] IFBL_OP_J       = 6'h02;
	localparam logic [5:0] IFBL_OP_JAL     = 6'h03;
	localparam logic [5:0] IFBL_OP_BEQ     = 6'h04;
	localparam logic [5:0] IFBL_OP_BGTZ    = 6'h07;
	localparam logic [5:0] IFBL_OP_ADDI    = 6'h08;
	localparam logic [5:0] IFBL_OP_LUI     = 6'h0f;
	localparam logic [5:0] IFBL_OP_COP0    = 6'h10;
	localparam logic [5:0] IFBL_OP_COP1    = 6'h11;
	localparam logic [5:0] IFBL_OP_COP2    = 6'h12;
	localparam logic [5:0] IFBL_OP_COP1X   = 6'h13;
	localparam logic [5:0] IFBL_OP_LB      = 6'h20;
	localparam logic [5:0] IFBL_OP_LH      = 6'h21;
	localparam logic [5:0] IFBL_OP_LW_LEFT  = 6'h22;
	localparam logic [5:0] IFBL_OP_LW      = 6'h23;
	localparam logic [5:0] IFBL_OP_LBU     = 6'h24;
	localparam logic [5:0] IFBL_OP_LHU     = 6'h25;
	localparam logic [5:0] IFBL_OP_LW_RIGHT = 6'h26;
	localparam logic [5:0] IFBL_OP_LWU     = 6'h27;
	localparam logic [5:0] IFBL_OP_SB      = 6'h28;
	localparam logic [5:0] IFBL_OP_SH      = 6'h29;
	localparam logic [5:0] IFBL_OP_SW_LEFT  = 6'h2a;
	localparam logic [5:0] IFBL_OP_SW      = 6'h2b;
	localparam logic [5:0] IFBL_OP_SD_LEFT  = 6'h2c;
	localparam logic [5:0] IFBL_OP_SD_RIGHT = 6'h2d;
	localparam logic [5:0] IFBL_OP_SW_RIGHT = 6'h2e;
	localparam logic [5:0] IFBL_OP_LD_LEFT  = 6'h1a;
	localparam logic [5:0] IFBL_OP_LD_RIGHT = 6'h1b;
	localparam logic [5:0] IFBL_OP_LWC1    = 6'h31;
	localparam logic [5:0] IFBL_OP_LDC1    = 6'h35;
	localparam logic [5:0] IFBL_OP_LD      = 6'h37;
	localparam logic [5:0] IFBL_OP_SWC1    = 6'h39;
	localparam logic [5:0] IFBL_OP_SDC1    = 6'h3d;
	localparam logic [5:0] IFBL_OP_SD      = 6'h3f;

	// Function codes of the register layout.
	localparam logic [5:0] IFBL_FN_JR      = 6'h08;
	localparam logic [5:0] IFBL_FN_JALR    = 6'h09;
	localparam logic [5:0] IFBL_FN_SYSCALL = 6'h0c;
	localparam logic [5:0] IFBL_FN_BREAK   = 6'h0d;
	localparam logic [5:0] IFBL_FN_TGE     = 6'h30;
	localparam logic [5:0] IFBL_FN_TNE     = 6'h36;
	// Regimm rt codes: traps 0x08..0x0e, links 0x10..0x13.
	localparam logic [4:0] IFBL_RI_TGEI    = 5'h08;
	localparam logic [4:0] IFBL_RI_TNEI    = 5'h0e;
	localparam logic [4:0] IFBL_RI_LINK    = 5'h10;
	localparam logic [4:0] IFBL_RI_LINKMAX = 5'h13;
	// Indexed floating-point load/store function codes.
	localparam logic [5:0] IFBL_FX_LDMAX   = 6'h07;
	localparam logic [5:0] IFBL_FX_STMIN   = 6'h08;
	localparam logic [5:0] IFBL_FX_STMAX   = 6'h0f;

	localparam logic [4:0] IFBL_ZERO_REG   = 5'h00;
	localparam logic [4:0] IFBL_LINK_REG   = 5'h1f;
	localparam logic [63:0] IFBL_PC_STEP   = 64'h0000_0000_0000_0008;

	// Extra cycles for a left/right part access.
	localparam logic [1:0] IFBL_PART_EXTRA = 2'h1;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		IFBL_FMT_I = 3'b001,
		IFBL_FMT_J = 3'b010,
		IFBL_FMT_R = 3'b100
	} ifbl_fmt_type;

	typedef enum logic [1:0] {
		IFBL_SZ_BYTE  = 2'h0,
		IFBL_SZ_HALF  = 2'h1,
		IFBL_SZ_WORD  = 2'h2,
		IFBL_SZ_DWORD = 2'h3
	} ifbl_size_type;

	typedef enum logic [6:0] {
		IFBL_CLS_NONE = 7'b000_0001,
		IFBL_CLS_LDST = 7'b000_0010,
		IFBL_CLS_COMP = 7'b000_0100,
		IFBL_CLS_JBR  = 7'b000_1000,
		IFBL_CLS_COP  = 7'b001_0000,
		IFBL_CLS_SYS  = 7'b010_0000,
		IFBL_CLS_EXC  = 7'b100_0000
	} ifbl_class_type;

	typedef enum logic [1:0] {
		IFBL_ST_IDLE = 2'b01,
		IFBL_ST_PART = 2'b10
	} ifbl_state_type;

	typedef struct packed {
		logic        valid;
		logic [31:0] instr;
		logic [63:0] pc;
		logic [63:0] rs_val;
		logic [63:0] rt_val;
	} ifbl_req_type;

	typedef struct packed {
		logic           valid;
		ifbl_fmt_type   fmt;
		ifbl_class_type cls;
		logic [4:0]     rs;
		logic [4:0]     rt;
		logic [4:0]     dest;
		logic           dest_we;
		logic [63:0]    src_b;
		logic [63:0]    addr;
		logic           mem_rd;
		logic           mem_wr;
		logic           fp_dp;
		logic           mmx;
		logic           sysreg_rd;
		logic           sysreg_wr;
		logic           redirect;
		logic [63:0]    target;
		logic           syscall_exc;
		logic           break_exc;
		logic           trap_exc;
		logic           addr_err;
		logic           left_part;
		logic           right_part;
		ifbl_size_type  size;
		logic [7:0]     lane_mask;
		logic [63:0]    store_data;
	} ifbl_dec_type;

	typedef struct packed {
		ifbl_state_type state;
		logic           busy;
		ifbl_dec_type   out;
	} ifbl_regs_type;

endpackage

// [ifbl_decoder.sv]
`timescale 1ns/1ps
module ifbl_decoder
	import ifbl_pkg::*;
(
	input  wire logic         clock,
	input  wire logic         arst_n,
	input  wire logic         big_endian,
	input  wire ifbl_req_type req,
	output ifbl_dec_type      dec,
	output logic              busy
);

	ifbl_regs_type state_r;
	ifbl_regs_type state_nxt;

	assign dec  = state_r.out;
	assign busy = state_r.busy;

	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	always_comb begin
		logic [5:0]  opc;
		logic [5:0]  fn;
		logic [4:0]  rs;
		logic [4:0]  rt;
		logic [4:0]  rd;
		logic [63:0] simm;
		logic [63:0] rs_v;
		logic [63:0] rt_v;
		logic [63:0] base;
		logic [63:0] ea;
		logic [2:0]  boff;
		logic [3:0]  nbytes;
		logic        is_load;
		logic        is_store;
		logic        is_fpx;
		logic        misal;
		logic        take;
		logic [2:0]  lane;
		ifbl_dec_type d;
		opc      = req.instr[IFBL_OPC_LSB +: 6];
		fn       = req.instr[IFBL_FUNCT_LSB +: 6];
		rs       = req.instr[IFBL_RS_LSB +: 5];
		rt       = req.instr[IFBL_RT_LSB +: 5];
		rd       = req.instr[IFBL_RD_LSB +: 5];
		simm     = {{48{req.instr[IFBL_IMM_W-1]}},
			req.instr[IFBL_IMM_W-1:0]};
		// Register 0 always reads as zero.
		rs_v     = (rs == IFBL_ZERO_REG) ? 64'h0 : req.rs_val;
		rt_v     = (rt == IFBL_ZERO_REG) ? 64'h0 : req.rt_val;
		base     = rs_v;
		is_load  = 1'b0;
		is_store = 1'b0;
		is_fpx   = 1'b0;
		take     = 1'b0;
		nbytes   = 4'h0;
		ea       = 64'h0;
		boff     = 3'h0;
		misal    = 1'b0;
		lane     = 3'h0;
		d        = '0;
		d.valid  = req.valid;
		d.rs     = rs;
		d.rt     = rt;
		d.cls    = IFBL_CLS_NONE;
		d.size   = IFBL_SZ_WORD;
		d.src_b  = rt_v;

		// Layout selection from the opcode.
		case (opc)
		IFBL_OP_SPECIAL: d.fmt = IFBL_FMT_R;
		IFBL_OP_J, IFBL_OP_JAL: d.fmt = IFBL_FMT_J;
		default: d.fmt = IFBL_FMT_I;
		endcase

		// ---------------------------------------------------------------
		// Classification
		// ---------------------------------------------------------------
		case (opc)
		IFBL_OP_SPECIAL: begin
			// Register jumps take the whole target from the source.
			if (fn == IFBL_FN_JR || fn == IFBL_FN_JALR) begin
				d.cls      = IFBL_CLS_JBR;
				d.redirect = 1'b1;
				d.target   = rs_v;
				if (fn == IFBL_FN_JALR) begin
					d.dest    = IFBL_LINK_REG;
					d.dest_we = 1'b1;
				end
			end else if (fn == IFBL_FN_SYSCALL) begin
				d.cls         = IFBL_CLS_EXC;
				d.syscall_exc = 1'b1;
			end else if (fn == IFBL_FN_BREAK) begin
				d.cls       = IFBL_CLS_EXC;
				d.break_exc = 1'b1;
			end else if (fn >= IFBL_FN_TGE && fn <= IFBL_FN_TNE) begin
				// The low function bits pick the compare of the trap.
				d.cls = IFBL_CLS_EXC;
				case (fn[2:0])
				3'h0: take = $signed(rs_v) >= $signed(rt_v);
				3'h1: take = rs_v >= rt_v;
				3'h2: take = $signed(rs_v) < $signed(rt_v);
				3'h3: take = rs_v < rt_v;
				3'h4: take = rs_v == rt_v;
				3'h6: take = rs_v != rt_v;
				default: take = 1'b0;
				endcase
				d.trap_exc = take;
			end else begin
				d.cls     = IFBL_CLS_COMP;
				d.dest    = rd;
				d.dest_we = 1'b1;
			end
		end
		IFBL_OP_REGIMM: begin
			// Immediate traps compare against the sign-extended offset.
			if (rt >= IFBL_RI_TGEI && rt <= IFBL_RI_TNEI) begin
				d.cls = IFBL_CLS_EXC;
				case (rt[2:0])
				3'h0: take = $signed(rs_v) >= $signed(simm);
				3'h1: take = rs_v >= simm;
				3'h2: take = $signed(rs_v) < $signed(simm);
				3'h3: take = rs_v < simm;
				3'h4: take = rs_v == simm;
				3'h6: take = rs_v != simm;
				default: take = 1'b0;
				endcase
				d.trap_exc = take;
			end else begin
				d.cls      = IFBL_CLS_JBR;
				d.redirect = rt[0] ? !rs_v[63] : rs_v[63];
				d.target   = req.pc + (simm << 2);
				if (rt >= IFBL_RI_LINK && rt <= IFBL_RI_LINKMAX) begin
					d.dest    = IFBL_LINK_REG;
					d.dest_we = 1'b1;
				end
			end
		end
		IFBL_OP_J, IFBL_OP_JAL: begin
			d.cls      = IFBL_CLS_JBR;
			d.redirect = 1'b1;
			d.target   = {req.pc[63:IFBL_TGT_W+2],
				req.instr[IFBL_TGT_W-1:0], 2'b00};
			if (opc == IFBL_OP_JAL) begin
				d.dest    = IFBL_LINK_REG;
				d.dest_we = 1'b1;
			end
		end
		IFBL_OP_COP0: begin
			// Bit 2 of the source field marks a move into the register.
			d.cls       = IFBL_CLS_SYS;
			d.sysreg_rd = !rs[2];
			d.sysreg_wr = rs[2];
			d.dest      = rs[2] ? rd : rt;
			d.dest_we   = !rs[2];
		end
		IFBL_OP_COP1: begin
			d.cls   = IFBL_CLS_COP;
			d.fp_dp = 1'b1;
		end
		IFBL_OP_COP2: begin
			d.cls = IFBL_CLS_COP;
			d.mmx = 1'b1;
		end
		IFBL_OP_COP1X: begin
			d.cls   = IFBL_CLS_COP;
			d.fp_dp = 1'b1;
			// Indexed accesses add the second register to the base.
			if (fn <= IFBL_FX_LDMAX || (fn >= IFBL_FX_STMIN &&
				fn <= IFBL_FX_STMAX)) begin
				is_fpx   = 1'b1;
				is_load  = fn <= IFBL_FX_LDMAX;
				is_store = !is_load;
				d.size   = fn[0] ? IFBL_SZ_DWORD : IFBL_SZ_WORD;
			end
		end
		default: begin
			if (opc >= IFBL_OP_BEQ && opc <= IFBL_OP_BGTZ) begin
				d.cls = IFBL_CLS_JBR;
				case (opc[1:0])
				2'h0: d.redirect = rs_v == rt_v;
				2'h1: d.redirect = rs_v != rt_v;
				2'h2: d.redirect = $signed(rs_v) <= 0;
				default: d.redirect = $signed(rs_v) > 0;
				endcase
				d.target = req.pc + (simm << 2);
			end else if (opc >= IFBL_OP_ADDI && opc <= IFBL_OP_LUI) begin
				d.cls     = IFBL_CLS_COMP;
				d.src_b   = simm;
				d.dest    = rt;
				d.dest_we = 1'b1;
			end else begin
				case (opc)
				IFBL_OP_LB, IFBL_OP_LBU: d.size = IFBL_SZ_BYTE;
				IFBL_OP_LH, IFBL_OP_LHU: d.size = IFBL_SZ_HALF;
				IFBL_OP_SB: d.size = IFBL_SZ_BYTE;
				IFBL_OP_SH: d.size = IFBL_SZ_HALF;
				IFBL_OP_LD_LEFT, IFBL_OP_LD_RIGHT, IFBL_OP_LD,
				IFBL_OP_LDC1, IFBL_OP_SD_LEFT, IFBL_OP_SD_RIGHT,
				IFBL_OP_SD, IFBL_OP_SDC1: d.size = IFBL_SZ_DWORD;
				default: d.size = IFBL_SZ_WORD;
				endcase
				case (opc)
				IFBL_OP_LB, IFBL_OP_LH, IFBL_OP_LW_LEFT, IFBL_OP_LW,
				IFBL_OP_LBU, IFBL_OP_LHU, IFBL_OP_LW_RIGHT, IFBL_OP_LWU,
				IFBL_OP_LD_LEFT, IFBL_OP_LD_RIGHT, IFBL_OP_LD,
				IFBL_OP_LWC1, IFBL_OP_LDC1: is_load = 1'b1;
				IFBL_OP_SB, IFBL_OP_SH, IFBL_OP_SW_LEFT, IFBL_OP_SW,
				IFBL_OP_SW_RIGHT, IFBL_OP_SD_LEFT, IFBL_OP_SD_RIGHT,
				IFBL_OP_SD, IFBL_OP_SWC1, IFBL_OP_SDC1: is_store = 1'b1;
				default: ;
				endcase
				case (opc)
				IFBL_OP_LW_LEFT, IFBL_OP_SW_LEFT, IFBL_OP_LD_LEFT,
				IFBL_OP_SD_LEFT: d.left_part = 1'b1;
				IFBL_OP_LW_RIGHT, IFBL_OP_SW_RIGHT, IFBL_OP_LD_RIGHT,
				IFBL_OP_SD_RIGHT: d.right_part = 1'b1;
				default: ;
				endcase
			end
		end
		endcase

		// ---------------------------------------------------------------
		// Address, alignment and byte lanes
		// ---------------------------------------------------------------
		ea = is_fpx ? (base + rt_v) : (base + simm);
		if (is_load || is_store) begin
			d.cls    = (d.cls == IFBL_CLS_COP) ? IFBL_CLS_COP : IFBL_CLS_LDST;
			d.addr   = ea;
			if (is_load && !is_fpx) begin
				d.dest    = rt;
				d.dest_we = 1'b1;
			end
			case (d.size)
			IFBL_SZ_BYTE:  misal = 1'b0;
			IFBL_SZ_HALF:  misal = ea[0];
			IFBL_SZ_WORD:  misal = ea[1:0] != 2'b00;
			default:       misal = ea[2:0] != 3'b000;
			endcase
			// Part accesses are the way round the alignment check.
			if (d.left_part || d.right_part)
				misal = 1'b0;
			d.addr_err = misal;
			d.mem_rd   = is_load && !misal;
			d.mem_wr   = is_store && !misal;
			boff       = ea[2:0];
			case (d.size)
			IFBL_SZ_BYTE:  nbytes = 4'h1;
			IFBL_SZ_HALF:  nbytes = 4'h2;
			IFBL_SZ_WORD:  nbytes = 4'h4;
			default:       nbytes = 4'h8;
			endcase
			// Left part covers offset..end of unit, right part start..offset
			// in big-endian; little-endian mirrors the two.
			for (int k = 0; k < 8; k++) begin
				logic [3:0] kb;
				logic [3:0] ub;
				kb = 4'(k);
				ub = (nbytes == 4'h8) ? 4'h0 : {1'b0, boff & 3'b100};
				if (!d.left_part && !d.right_part)
					d.lane_mask[k] = !misal && kb >= {1'b0, boff} &&
						kb < {1'b0, boff} + nbytes;
				else if (d.left_part ^ !big_endian)
					d.lane_mask[k] = kb >= {1'b0, boff} &&
						kb < ub + nbytes;
				else
					d.lane_mask[k] = kb >= ub &&
						kb <= {1'b0, boff};
				// Byte address k lands on a data-bus lane by endianness.
				lane = big_endian ? (3'h7 - 3'(k)) : 3'(k);
				d.store_data[8*lane +: 8] = rt_v[8*((k - int'(boff)) & 7)
					+: 8];
			end
		end
		if (d.dest == IFBL_ZERO_REG)
			d.dest_we = 1'b0;


		// ---------------------------------------------------------------
		// Stall control
		// ---------------------------------------------------------------
		// A part access holds its result for one more cycle while the
		// source is told to wait, so each part access costs one extra cycle.
		state_nxt      = state_r;
		state_nxt.out  = d;
		case (state_r.state)
		IFBL_ST_IDLE: begin
			if (d.valid && (d.left_part || d.right_part)) begin
				state_nxt.state = IFBL_ST_PART;
				state_nxt.busy  = 1'b1;
			end
		end
		IFBL_ST_PART: begin
			// Extra processor cycle: hold the decoded part access.
			state_nxt.out   = state_r.out;
			state_nxt.state = IFBL_ST_IDLE;
			state_nxt.busy  = 1'b0;
		end
		default: state_nxt.state = IFBL_ST_IDLE;
		endcase
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_r       <= '0;
			state_r.state <= IFBL_ST_IDLE;
			state_r.out.cls <= IFBL_CLS_NONE;
			state_r.out.fmt <= IFBL_FMT_I;
		end else begin
			state_r <= state_nxt;
		end
	end

endmodule // ifbl_decoder

// [ifbl_chk.sv]
`timescale 1ns/1ps
module ifbl_chk
	import ifbl_pkg::*;
(
	input wire logic         clock,
	input wire logic         arst_n,
	input wire logic         big_endian,
	input wire ifbl_req_type req,
	input wire ifbl_dec_type dec,
	input wire logic         busy
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	logic [5:0]  opc;
	logic        part;
	logic [63:0] amsk;

	assign opc  = req.instr[31:26];
	assign part = opc inside {IFBL_OP_LW_LEFT, IFBL_OP_LW_RIGHT,
		IFBL_OP_SW_LEFT, IFBL_OP_SW_RIGHT, IFBL_OP_LD_LEFT,
		IFBL_OP_LD_RIGHT, IFBL_OP_SD_LEFT, IFBL_OP_SD_RIGHT};
	assign amsk = (64'h0001 << dec.size) - 64'h0001;

	sequence s_take;
		req.valid && !busy;
	endsequence
	sequence s_stall;
		busy ##1 !busy;
	endsequence

	a_part_stall: assert property (s_take ##0 part |=> s_stall)
		else $error("part access stall wrong");
	a_dec_lat: assert property (s_take |=> dec.valid)
		else $error("decode result missing");
	a_stall_hold: assert property (busy |=> $stable(dec))
		else $error("result changed during stall");
	a_jal_link: assert property (s_take ##0 opc == IFBL_OP_JAL |=>
		dec.dest == IFBL_LINK_REG && dec.dest_we)
		else $error("link register not written");
	a_jump_tgt: assert property (s_take ##0 opc == IFBL_OP_J |=>
		dec.target == {$past(req.pc[63:28]), $past(req.instr[25:0]), 2'b00})
		else $error("jump target wrong");
	a_load_addr: assert property (s_take ##0 opc == IFBL_OP_LW |=>
		dec.addr == $past(req.rs_val) + {{48{$past(req.instr[15])}},
		$past(req.instr[15:0])})
		else $error("load address wrong");
	a_zero_dest: assert property (dec.dest == IFBL_ZERO_REG |->
		!dec.dest_we)
		else $error("write to zero register");
	a_mem_align: assert property ((dec.mem_rd || dec.mem_wr) &&
		!dec.left_part && !dec.right_part |-> (dec.addr & amsk) == 64'h0)
		else $error("misaligned transfer issued");
	a_err_nomem: assert property (dec.addr_err |-> !dec.mem_rd &&
		!dec.mem_wr && dec.lane_mask == 8'h00)
		else $error("address error with transfer");
	a_cop2_mmx: assert property (s_take ##0 opc == IFBL_OP_COP2 |=>
		dec.mmx)
		else $error("multimedia decode missing");
endmodule // ifbl_chk

bind ifbl_decoder ifbl_chk ifbl_chk_inst (.clock(clock), .arst_n(arst_n),
	.big_endian(big_endian), .req(req), .dec(dec), .busy(busy));

// [ifbl_fetch_model.sv]
`timescale 1ns/1ps
module ifbl_fetch_model
	import ifbl_pkg::*;
(
	input  wire logic  clock,
	input  wire logic  busy,
	output ifbl_req_type req,
	output logic       big_endian
);
	initial begin
		req = '0;
		big_endian = 1'b0;
	end

	// Released fields flip so a stale value is never mistaken for data.
	task automatic idle();
		req <= {1'b0, ~req[$bits(req)-2:0]};
	endtask

	task automatic issue(input logic [31:0] i, input logic [63:0] pc,
		input logic [63:0] rs, input logic [63:0] rt, input logic be);
		@(negedge clock);
		while (busy !== 1'b0) begin
			idle();
			@(negedge clock);
		end
		req <= '{1'b1, i, pc, rs, rt};
		big_endian <= be;
	endtask
endmodule // ifbl_fetch_model

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	import ifbl_pkg::*;

	typedef struct {
		ifbl_class_type cls;
		logic [10:0]    f;
		logic [10:0]    fk;
		logic [7:0]     m;
		logic [4:0]     dst;
		logic [1:0]     sel;
		logic [63:0]    v;
		logic [4:0]     care;
	} ifbl_exp_type;

	localparam logic [10:0] F_RD = 11'h400, F_WR = 11'h200, F_AE = 11'h100;
	localparam logic [10:0] F_RED = 11'h080, F_WE = 11'h040, F_L = 11'h020;
	localparam logic [10:0] F_R = 11'h010, F_EX = 11'h008, F_SR = 11'h004;
	localparam logic [10:0] F_SW = 11'h002, F_MM = 11'h001, FA = 11'h7ff;
	// Span of all tests with a wide margin.
	localparam int WD_NS = 2000 * 10;

	logic         clock, arst_n, big_endian, busy;
	ifbl_req_type req;
	ifbl_dec_type dec;
	ifbl_exp_type e;
	ifbl_exp_type q[$];
	int           err_count, checks, o, sz;
	logic [31:0]  seed, r;
	logic [63:0]  b, pc;
	logic [15:0]  imm;
	logic [5:0]   lop[4], sop[4], pop[8];
	logic [31:0]  exc[4];

	ifbl_decoder ifbl_decoder_inst (.clock(clock), .arst_n(arst_n),
		.big_endian(big_endian), .req(req), .dec(dec), .busy(busy));
	ifbl_fetch_model ifbl_fetch_model_inst (.clock(clock), .busy(busy),
		.req(req), .big_endian(big_endian));

	always #5 clock = ~clock;

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [63:0] sx(input logic [15:0] v);
		return {{48{v[15]}}, v};
	endfunction

	task automatic cmp(input string n, input logic [63:0] g, input logic [63:0] x);
		checks++;
		if (g !== x) begin
			err_count++;
			$display("MISMATCH %0t %s got %h exp %h", $time, n, g, x);
		end
	endtask

	task automatic go(input logic [31:0] i, input logic [63:0] rs,
		input logic [63:0] rt, input logic be);
		q.push_back(e);
		ifbl_fetch_model_inst.issue(i, pc, rs, rt, be);
	endtask

	task automatic done(input string n);
		@(negedge clock);
		ifbl_fetch_model_inst.idle();
		repeat (3) @(negedge clock);
		$display("test %s done", n);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	always @(negedge clock) begin : mon
		ifbl_exp_type x;
		logic [63:0]  v;
		logic [10:0]  fl;
		if (dec.valid === 1'b1 && busy === 1'b0) begin
			fl = {dec.mem_rd, dec.mem_wr, dec.addr_err, dec.redirect,
				dec.dest_we, dec.left_part, dec.right_part, dec.syscall_exc |
				dec.break_exc | dec.trap_exc, dec.sysreg_rd, dec.sysreg_wr, dec.mmx};
			if (q.size() == 0) begin
				cmp("extra", 64'h0001, 64'h0000);
			end else begin
				x = q.pop_front();
				case (x.sel)
					2'h0: v = dec.addr;
					2'h1: v = dec.target;
					2'h2: v = dec.src_b;
					default: begin
						v = (dec.store_data >> x.v[13:8]) & 64'h00ff;
						x.v = x.v & 64'h00ff;
					end
				endcase
				if (x.care[4]) cmp("class", 64'(dec.cls), 64'(x.cls));
				if (x.care[3]) cmp("flags", 64'(fl & x.fk), 64'(x.f & x.fk));
				if (x.care[2]) cmp("lanes", 64'(dec.lane_mask), 64'(x.m));
				if (x.care[1]) cmp("dest", 64'(dec.dest), 64'(x.dst));
				if (x.care[0]) cmp("value", v, x.v);
			end
		end
	end

	initial begin
		#WD_NS;
		err_count++;
		$display("MISMATCH %0t watchdog expired", $time);
		summarize();
	end

	initial begin
		clock = 1'b0;
		arst_n = 1'b0;
		seed = 32'h0000_cef8;
		err_count = 0;
		checks = 0;
		pc = 64'h0;
		lop = '{IFBL_OP_LB, IFBL_OP_LH, IFBL_OP_LW, IFBL_OP_LD};
		sop = '{IFBL_OP_SB, IFBL_OP_SH, IFBL_OP_SW, IFBL_OP_SD};
		pop = '{IFBL_OP_LW_LEFT, IFBL_OP_LW_RIGHT, IFBL_OP_LD_LEFT,
			IFBL_OP_LD_RIGHT, IFBL_OP_SW_LEFT, IFBL_OP_SW_RIGHT,
			IFBL_OP_SD_LEFT, IFBL_OP_SD_RIGHT};
		exc = '{{26'h0, IFBL_FN_SYSCALL}, {26'h0, IFBL_FN_BREAK},
			{6'h0, 5'h01, 5'h02, 10'h0, IFBL_FN_TNE},
			{IFBL_OP_REGIMM, 5'h01, IFBL_RI_TGEI, 16'h0004}};
		repeat (2) @(negedge clock);
		cmp("reset", 64'({dec.valid, busy, dec.cls}), 64'({2'b00, IFBL_CLS_NONE}));
		arst_n = 1'b1;
		for (int k = 0; k < 8; k++) begin
			r = rnd();
			b = {rnd(), r} & ~64'h0007;
			sz = k % 4;
			o = (r[20:16] % (8 >> sz)) << sz;
			imm = {r[15:3], 3'(o)};
			e = '{IFBL_CLS_LDST, F_RD | F_WE, FA, 8'(((1 << (1 << sz)) - 1) << o),
				5'h09, 2'h0, b + sx(imm), 5'h1f};
			go({lop[sz], 5'h03, 5'h09, imm}, b, 64'h0, r[31]);
		end
		done("aligned");
		for (int k = 1; k < 4; k++) begin
			for (int s = 0; s < 2; s++) begin
				b = {rnd(), rnd()} & ~64'h0007;
				imm = 16'(1 << (k - 1));
				e = '{IFBL_CLS_LDST, F_AE, FA, 8'h00, 5'h00, 2'h0, b + sx(imm),
					s ? 5'h1d : 5'h1f};
				go({s ? sop[k] : lop[k], 5'h03, 5'h00, imm}, b, 64'h0, 1'b0);
			end
		end
		done("misaligned");
		for (int k = 0; k < 8; k++) begin
			r = rnd();
			b = {r, r} & ~64'h0007;
			o = k % 4;
			e = '{IFBL_CLS_LDST, F_WR, FA, 8'(1 << o), 5'h00, 2'h3,
				{50'h0, 6'(k < 4 ? 56 - 8 * o : 8 * o), r[7:0]}, 5'h1d};
			go({IFBL_OP_SB, 5'h03, 5'h07, 16'(o)}, b, {32'h0, r}, k < 4);
		end
		done("byte lanes");
		for (int k = 0; k < 8; k++) begin
			b = {rnd(), rnd()} & ~64'h0007;
			e = '{IFBL_CLS_LDST, (k < 4 ? F_RD | F_WE : F_WR) | (k % 2 ? F_R : F_L),
				FA, 8'h0f, 5'h0a, 2'h0, b + 64'h0003, k < 4 ? 5'h1f : 5'h1d};
			go({pop[k], 5'h03, 5'h0a, 16'h0003}, b, 64'h0, 1'(k));
		end
		done("part pairs");
		pc = {rnd(), rnd()} & ~64'h0003;
		r = rnd();
		b = {rnd(), r};
		e = '{IFBL_CLS_JBR, F_RED, FA, 8'h00, 5'h00, 2'h1,
			{pc[63:28], r[25:0], 2'b00}, 5'h19};
		go({IFBL_OP_J, r[25:0]}, b, 64'h0, 1'b0);
		e = '{IFBL_CLS_JBR, F_RED | F_WE, FA, 8'h00, IFBL_LINK_REG, 2'h1,
			{pc[63:28], r[25:0], 2'b00}, 5'h1b};
		go({IFBL_OP_JAL, r[25:0]}, b, 64'h0, 1'b0);
		e = '{IFBL_CLS_JBR, F_RED, FA, 8'h00, 5'h00, 2'h1, b, 5'h19};
		go({6'h00, 5'h07, 15'h0, IFBL_FN_JR}, b, 64'h0, 1'b0);
		imm = r[31:16];
		e = '{IFBL_CLS_JBR, F_RED, FA, 8'h00, 5'h00, 2'h1, pc + (sx(imm) << 2),
			5'h19};
		go({IFBL_OP_BEQ, 5'h01, 5'h02, imm}, b, b, 1'b0);
		done("control");
		e = '{IFBL_CLS_COMP, F_WE, FA, 8'h00, 5'h05, 2'h2, sx(imm), 5'h1b};
		go({IFBL_OP_ADDI, 5'h01, 5'h05, imm}, b, 64'h0, 1'b0);
		e = '{IFBL_CLS_COMP, 11'h000, FA, 8'h00, 5'h00, 2'h2, sx(imm), 5'h1b};
		go({IFBL_OP_ADDI, 5'h01, 5'h00, imm}, b, 64'h0, 1'b0);
		e = '{IFBL_CLS_COMP, F_WE, FA, 8'h00, 5'h0c, 2'h2, {r, r}, 5'h1b};
		go({6'h00, 5'h01, 5'h02, 5'h0c, 5'h00, 6'h20}, b, {r, r}, 1'b0);
		for (int k = 0; k < 4; k++) begin
			e = '{IFBL_CLS_EXC, F_EX, F_EX | F_RD | F_WR, 8'h00, 5'h00, 2'h0,
				64'h0, 5'h18};
			go(exc[k], 64'h0005, 64'h0006, 1'b0);
		end
		done("compute and exceptions");
		e = '{IFBL_CLS_SYS, F_SR, F_SR | F_SW, 8'h00, 5'h00, 2'h0, 64'h0, 5'h18};
		go({IFBL_OP_COP0, 5'h00, 5'h04, 5'h0c, 11'h0}, b, 64'h0, 1'b0);
		e = '{IFBL_CLS_SYS, F_SW, F_SR | F_SW, 8'h00, 5'h00, 2'h0, 64'h0, 5'h18};
		go({IFBL_OP_COP0, 5'h04, 5'h04, 5'h0c, 11'h0}, b, 64'h0, 1'b0);
		e = '{IFBL_CLS_COP, F_MM, F_MM, 8'h00, 5'h00, 2'h0, 64'h0, 5'h18};
		go({IFBL_OP_COP2, 26'h0}, b, 64'h0, 1'b0);
		e = '{IFBL_CLS_COP, 11'h000, F_MM | F_RD | F_WR, 8'h00, 5'h00, 2'h0,
			64'h0, 5'h18};
		go({IFBL_OP_COP1, 5'h10, 21'h0}, b, 64'h0, 1'b0);
		b = b & ~64'h0007;
		e = '{IFBL_CLS_LDST, F_RD, F_RD | F_AE, 8'h00, 5'h00, 2'h0,
			b + 64'h0010, 5'h09};
		go({IFBL_OP_COP1X, 5'h01, 5'h02, 10'h0, 6'h01}, b, 64'h0010, 1'b0);
		done("coprocessor");
		cmp("pending", 64'(q.size()), 64'h0);
		summarize();
	end
endmodule // tb_top
